// File: hdl/rcpr_pkg.sv
// Package with register map, field layout and constants of the radio register group.
package rcpr_pkg;

    // Register offsets on the host register port.
    localparam logic [7:0] RCPR_OFS_CHANNEL = 8'h21;
    localparam logic [7:0] RCPR_OFS_STRENGTH = 8'h22;
    localparam logic [7:0] RCPR_OFS_TX_POWER = 8'h23;
    localparam logic [7:0] RCPR_OFS_XTAL = 8'h24;
    localparam logic [7:0] RCPR_OFS_OSC_CAL = 8'h26;

    // Field positions.
    localparam int RCPR_CH_SRC_BIT = 7;
    localparam int RCPR_CH_NUM_LSB = 0;
    localparam int RCPR_CH_NUM_W = 7;
    localparam int RCPR_SS_VALID_BIT = 5;
    localparam int RCPR_SS_LVL_LSB = 0;
    localparam int RCPR_SS_LVL_W = 5;
    localparam int RCPR_PWR_LSB = 0;
    localparam int RCPR_PWR_W = 3;
    localparam int RCPR_CLK_OFF_BIT = 6;
    localparam int RCPR_TRIM_LSB = 0;
    localparam int RCPR_TRIM_W = 6;
    localparam int RCPR_SLOPE_LSB = 6;
    localparam int RCPR_SLOPE_W = 2;

    // Reset values of every register of the group.
    localparam logic [7:0] RCPR_RST_CHANNEL = 8'h00;
    localparam logic [7:0] RCPR_RST_STRENGTH = 8'h00;
    localparam logic [7:0] RCPR_RST_TX_POWER = 8'h00;
    localparam logic [7:0] RCPR_RST_XTAL = 8'h00;
    localparam logic [7:0] RCPR_RST_OSC_CAL = 8'h00;

    // Channel code 1 is 2402 MHz, so the base is one step below it.
    localparam logic [11:0] RCPR_CH_BASE_MHZ = 12'h0961;

    // Slope adjustment codes and their down/up magnitudes.
    localparam logic [1:0] RCPR_SLOPE_WIDE = 2'h3;
    localparam logic [1:0] RCPR_SLOPE_NARROW = 2'h2;
    localparam logic [2:0] RCPR_WIDE_DN = 3'h5;
    localparam logic [2:0] RCPR_WIDE_UP = 3'h5;
    localparam logic [2:0] RCPR_NARROW_DN = 3'h2;
    localparam logic [2:0] RCPR_NARROW_UP = 3'h3;

    // Default width of the synthesizer counter words.
    localparam int RCPR_CNT_W = 8;

endpackage

// File: hdl/rcpr_regs.sv
// Radio channel, signal strength, power, crystal and oscillator registers.
`timescale 1ns/1ns
// Behaviour
// - Channel bit 7 picks counters or channel field.
// - Channel 1 is 2402 MHz, 1 MHz steps.
// - Strength register read-only, bits 7:6 reserved.
// - Strength bit 5 flags valid level.
// - Larger unsigned strength code means stronger signal.
// - One strength sample per receive mode entry.
// - Power code 0 lowest, 7 highest.
// - Clock-off bit 1 stops reference clock output.
// - Crystal trim field drives load capacitance.
// - Slope code 11, 10, 01, 00 decode; here only 11 and 10 give magnitudes, 01 and 00 both give zero.
// - Slope field write-only, host programs 11.
module rcpr_regs #(
    parameter int CNT_W = rcpr_pkg::RCPR_CNT_W
) (
    input  wire logic                    clk_sys,         // System clock.
    input  wire logic                    sys_rst,         // Async reset.
    input  wire logic [7:0]              reg_addr,        // Register offset.
    input  wire logic [7:0]              reg_wdata,       // Write data.
    input  wire logic                    reg_wr,          // Write strobe.
    input  wire logic                    reg_rd,          // Read strobe.
    output logic      [7:0]              reg_rdata,       // Read data.
    output logic                         reg_rvalid,      // Read data valid.
    input  wire logic [CNT_W-1:0]        synth_a_cnt,     // Counter reg 0x01.
    input  wire logic [CNT_W-1:0]        synth_n_cnt,     // Counter reg 0x02.
    input  wire logic                    rx_mode,         // Control 0x03 bit 7.
    input  wire logic [rcpr_pkg::RCPR_SS_LVL_W-1:0] rssi_level, // Level.
    input  wire logic                    rssi_level_ok,   // Analog level good.
    output logic                         synth_use_cnt,   // Counters in use.
    output logic      [11:0]             synth_freq_mhz,  // Channel frequency.
    output logic      [CNT_W-1:0]        synth_a_out,     // A counter to synth.
    output logic      [CNT_W-1:0]        synth_n_out,     // N counter to synth.
    output logic      [rcpr_pkg::RCPR_PWR_W-1:0] tx_power_level, // Tx_power_level.
    output logic                         ref_clock_out_en, // Drive clock pin.
    output logic      [rcpr_pkg::RCPR_TRIM_W-1:0] xtal_load_trim, // Load cap.
    output logic      [2:0]              osc_slope_dn,    // Slope down step.
    output logic      [2:0]              osc_slope_up     // Slope up step.
);
    import rcpr_pkg::*;

    if (CNT_W < 1 || CNT_W > 16) begin : g_chk
        $error("CNT_W must lie between 1 and 16");
    end

    // The field layout must fit one byte per register without overlap.
    if (RCPR_CH_NUM_LSB + RCPR_CH_NUM_W > RCPR_CH_SRC_BIT) begin : g_chk_ch
        $error("Channel field overlaps the source bit");
    end

    if (RCPR_CH_SRC_BIT > 7) begin : g_chk_src
        $error("Source bit lies outside the register");
    end

    if (RCPR_SS_LVL_LSB + RCPR_SS_LVL_W > RCPR_SS_VALID_BIT) begin : g_chk_ss
        $error("Strength level overlaps the valid bit");
    end

    if (RCPR_PWR_LSB + RCPR_PWR_W > 8) begin : g_chk_pw
        $error("Power field lies outside the register");
    end

    if (RCPR_TRIM_LSB + RCPR_TRIM_W > RCPR_CLK_OFF_BIT) begin : g_chk_xt
        $error("Trim field overlaps the clock-off bit");
    end

    if (RCPR_SLOPE_LSB + RCPR_SLOPE_W > 8) begin : g_chk_sl
        $error("Slope field lies outside the register");
    end

    if (int'(RCPR_CH_BASE_MHZ) + 2 ** RCPR_CH_NUM_W > 4096) begin : g_chk_fq
        $error("Highest channel does not fit the frequency word");
    end

    // All state of the block; one flop stage registers the whole of it.
    typedef struct packed {
        logic                     ch_src;
        logic [RCPR_CH_NUM_W-1:0] ch_num;
        logic [RCPR_SS_LVL_W-1:0] ss_lvl;
        logic                     ss_ok;
        logic                     rx_prev;
        logic [RCPR_PWR_W-1:0]    pwr;
        logic                     clk_off;
        logic [RCPR_TRIM_W-1:0]   trim;
        logic [RCPR_SLOPE_W-1:0]  slope;
        logic [7:0]               rdata;
        logic                     rvalid;
        logic                     use_cnt;
        logic [11:0]              freq;
        logic [CNT_W-1:0]         a_cnt;
        logic [CNT_W-1:0]         n_cnt;
        logic                     clk_en;
        logic [2:0]               sl_dn;
        logic [2:0]               sl_up;
    } rcpr_state_t;

    rcpr_state_t st_q;
    rcpr_state_t st_d;

    // Register picked by a host offset; unmapped offsets give none.
    typedef enum {
        RCPR_SEL_NONE,
        RCPR_SEL_CHANNEL,
        RCPR_SEL_STRENGTH,
        RCPR_SEL_TX_POWER,
        RCPR_SEL_XTAL,
        RCPR_SEL_OSC_CAL
    } rcpr_sel_t;

    // Offset decode, shared by the write and the read paths.
    function automatic rcpr_sel_t rcpr_decode(input logic [7:0] a);
        case (a)
            RCPR_OFS_CHANNEL: begin
                rcpr_decode = RCPR_SEL_CHANNEL;
            end
            RCPR_OFS_STRENGTH: begin
                rcpr_decode = RCPR_SEL_STRENGTH;
            end
            RCPR_OFS_TX_POWER: begin
                rcpr_decode = RCPR_SEL_TX_POWER;
            end
            RCPR_OFS_XTAL: begin
                rcpr_decode = RCPR_SEL_XTAL;
            end
            RCPR_OFS_OSC_CAL: begin
                rcpr_decode = RCPR_SEL_OSC_CAL;
            end
            default: begin
                rcpr_decode = RCPR_SEL_NONE;
            end
        endcase
    endfunction

    // Channel code to synthesizer frequency in MHz, 1 MHz per code.
    function automatic logic [11:0] rcpr_chan_freq(
        input logic [RCPR_CH_NUM_W-1:0] ch
    );
        rcpr_chan_freq = RCPR_CH_BASE_MHZ + 12'(ch);
    endfunction

    // Read view of one register. Reserved bits, unmapped offsets and the
    // write-only slope field all read as zero.
    function automatic logic [7:0] rcpr_read_word(input rcpr_sel_t sel,
                                                  input rcpr_state_t s);
        logic [7:0] w;
        w = 8'h00;
        case (sel)
            RCPR_SEL_CHANNEL: begin
                w[RCPR_CH_SRC_BIT] = s.ch_src;
                w[RCPR_CH_NUM_LSB +: RCPR_CH_NUM_W] = s.ch_num;
            end
            RCPR_SEL_STRENGTH: begin
                w[RCPR_SS_VALID_BIT] = s.ss_ok;
                w[RCPR_SS_LVL_LSB +: RCPR_SS_LVL_W] = s.ss_lvl;
            end
            RCPR_SEL_TX_POWER: begin
                w[RCPR_PWR_LSB +: RCPR_PWR_W] = s.pwr;
            end
            RCPR_SEL_XTAL: begin
                w[RCPR_CLK_OFF_BIT] = s.clk_off;
                w[RCPR_TRIM_LSB +: RCPR_TRIM_W] = s.trim;
            end
            // Reading the slope field gives zero, not the code.
            default: begin
                w = 8'h00;
            end
        endcase
        rcpr_read_word = w;
    endfunction

    // Slope code to down/up magnitude; the reserved code acts as none.
    function automatic logic [5:0] rcpr_slope(input logic [1:0] code);
        case (code)
            RCPR_SLOPE_WIDE: begin
                rcpr_slope = {RCPR_WIDE_DN, RCPR_WIDE_UP};
            end
            RCPR_SLOPE_NARROW: begin
                rcpr_slope = {RCPR_NARROW_DN, RCPR_NARROW_UP};
            end
            default: begin
                rcpr_slope = 6'h00;
            end
        endcase
    endfunction

    always_comb begin
        logic [5:0] sl;
        rcpr_sel_t  sel;
        logic       rx_rise;
        sl = 6'h00;
        sel = rcpr_decode(reg_addr);
        rx_rise = 1'b0;
        st_d = st_q;
        st_d.rvalid = 1'b0;

        // Reserved bits are dropped on write so they always read as zero.
        if (reg_wr) begin
            case (sel)
                RCPR_SEL_CHANNEL: begin
                    st_d.ch_src = reg_wdata[RCPR_CH_SRC_BIT];
                    st_d.ch_num = reg_wdata[RCPR_CH_NUM_LSB +: RCPR_CH_NUM_W];
                end
                RCPR_SEL_TX_POWER: begin
                    st_d.pwr = reg_wdata[RCPR_PWR_LSB +: RCPR_PWR_W];
                end
                RCPR_SEL_XTAL: begin
                    st_d.clk_off = reg_wdata[RCPR_CLK_OFF_BIT];
                    st_d.trim = reg_wdata[RCPR_TRIM_LSB +: RCPR_TRIM_W];
                end
                RCPR_SEL_OSC_CAL: begin
                    st_d.slope = reg_wdata[RCPR_SLOPE_LSB +: RCPR_SLOPE_W];
                end
                // A write to the read-only strength register is dropped.
                default: begin
                    // Unmapped offsets are ignored as well.
                end
            endcase
        end

        // Only the rising edge of receive mode samples, so the held
        // level cannot drift while the receiver stays on.
        rx_rise = rx_mode && !st_q.rx_prev;
        st_d.rx_prev = rx_mode;
        if (rx_rise) begin
            st_d.ss_lvl = rssi_level;
            st_d.ss_ok = rssi_level_ok;
        end

        // A read takes the old value even when a write hits the same
        // register in the same cycle.
        if (reg_rd) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = rcpr_read_word(sel, st_q);
        end

        // Frequency source steering. The counters pass only while they
        // are selected, so a stale count never reaches the synthesizer.
        st_d.use_cnt = st_q.ch_src;
        if (st_q.ch_src) begin
            st_d.a_cnt = synth_a_cnt;
            st_d.n_cnt = synth_n_cnt;
            st_d.freq = 12'h000;
        end else begin
            st_d.a_cnt = '0;
            st_d.n_cnt = '0;
            st_d.freq = rcpr_chan_freq(st_q.ch_num);
        end

        st_d.clk_en = !st_q.clk_off;
        // The slope magnitudes lag the slope register by one cycle, two after the write, like the rest.
        sl = rcpr_slope(st_q.slope);
        st_d.sl_dn = sl[5:3];
        st_d.sl_up = sl[2:0];
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            // Reset loads constants only; the derived outputs start from
            // what the register resets imply.
            st_q.ch_src <= RCPR_RST_CHANNEL[RCPR_CH_SRC_BIT];
            st_q.ch_num <= RCPR_RST_CHANNEL[RCPR_CH_NUM_LSB +: RCPR_CH_NUM_W];
            st_q.ss_ok <= RCPR_RST_STRENGTH[RCPR_SS_VALID_BIT];
            st_q.ss_lvl <= RCPR_RST_STRENGTH[RCPR_SS_LVL_LSB +: RCPR_SS_LVL_W];
            st_q.rx_prev <= 1'b0;
            st_q.pwr <= RCPR_RST_TX_POWER[RCPR_PWR_LSB +: RCPR_PWR_W];
            st_q.clk_off <= RCPR_RST_XTAL[RCPR_CLK_OFF_BIT];
            st_q.trim <= RCPR_RST_XTAL[RCPR_TRIM_LSB +: RCPR_TRIM_W];
            st_q.slope <= RCPR_RST_OSC_CAL[RCPR_SLOPE_LSB +: RCPR_SLOPE_W];
            st_q.rdata <= 8'h00;
            st_q.rvalid <= 1'b0;
            st_q.use_cnt <= RCPR_RST_CHANNEL[RCPR_CH_SRC_BIT];
            st_q.freq <= RCPR_CH_BASE_MHZ;
            st_q.a_cnt <= '0;
            st_q.n_cnt <= '0;
            st_q.clk_en <= ~RCPR_RST_XTAL[RCPR_CLK_OFF_BIT];
            st_q.sl_dn <= 3'h0;
            st_q.sl_up <= 3'h0;
        end else begin
            st_q <= st_d;
        end
    end

    // Every output is a plain copy of a state flop. The counter, frequency,
    // clock gate and slope outputs settle one cycle after the register
    // that feeds them; the host never sees that lag, but the synthesizer
    // and the crystal circuits do.
    assign reg_rdata = st_q.rdata;
    assign reg_rvalid = st_q.rvalid;
    assign synth_use_cnt = st_q.use_cnt;
    assign synth_freq_mhz = st_q.freq;
    assign synth_a_out = st_q.a_cnt;
    assign synth_n_out = st_q.n_cnt;
    assign tx_power_level = st_q.pwr;
    assign ref_clock_out_en = st_q.clk_en;
    assign xtal_load_trim = st_q.trim;
    assign osc_slope_dn = st_q.sl_dn;
    assign osc_slope_up = st_q.sl_up;

endmodule

// File: tb/rcpr_regs_monitor.sv
// Concurrent checks on the host port and outputs of the register group.
`timescale 1ns/1ns
module rcpr_regs_monitor (
    input logic        clk_sys,          // Clock.
    input logic        sys_rst,          // Async reset.
    input logic [7:0]  reg_addr,         // Offset.
    input logic [7:0]  reg_wdata,        // Write data.
    input logic        reg_wr,           // Write strobe.
    input logic        reg_rd,           // Read strobe.
    input logic [7:0]  reg_rdata,        // Read data.
    input logic [2:0]  tx_power_level,   // Bias code.
    input logic        ref_clock_out_en, // Clock pin drive.
    input logic [5:0]  xtal_load_trim,   // Load trim.
    input logic        synth_use_cnt,    // Counters in use.
    input logic [11:0] synth_freq_mhz,   // Channel frequency.
    input logic [2:0]  osc_slope_dn,     // Slope down.
    input logic [2:0]  osc_slope_up      // Slope up.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_src;
        reg_wr && reg_addr == 8'h21 |-> ##2
            synth_use_cnt == $past(reg_wdata[7], 2);
    endproperty
    a_src: assert property (p_src) else $error("source select wrong");
    property p_freq;
        reg_wr && reg_addr == 8'h21 && !reg_wdata[7] |-> ##2
            synth_freq_mhz == 12'h0961 + $past(reg_wdata[6:0], 2);
    endproperty
    a_freq: assert property (p_freq) else $error("frequency wrong");
    property p_ss;
        reg_rd && reg_addr == 8'h22 |=> reg_rdata[7:6] == 2'b00;
    endproperty
    a_ss: assert property (p_ss) else $error("strength high bits set");
    property p_pwr;
        reg_wr && reg_addr == 8'h23 |=>
            tx_power_level == $past(reg_wdata[2:0]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power code wrong");
    property p_clk;
        reg_wr && reg_addr == 8'h24 |-> ##2
            ref_clock_out_en != $past(reg_wdata[6], 2);
    endproperty
    a_clk: assert property (p_clk) else $error("clock gate wrong");
    property p_trim;
        reg_wr && reg_addr == 8'h24 |=>
            xtal_load_trim == $past(reg_wdata[5:0]);
    endproperty
    a_trim: assert property (p_trim) else $error("trim wrong");
    property p_slope;
        reg_wr && reg_addr == 8'h26 && reg_wdata[7:6] == 2'b11 |-> ##2
            osc_slope_dn == 3'h5 && osc_slope_up == 3'h5;
    endproperty
    a_slope: assert property (p_slope) else $error("slope wrong");
    property p_wo;
        reg_rd && reg_addr == 8'h26 |=> reg_rdata == 8'h00;
    endproperty
    a_wo: assert property (p_wo) else $error("slope read not 0");
endmodule
bind rcpr_regs rcpr_regs_monitor u_rcpr_regs_monitor (.clk_sys, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_power_level,
    .ref_clock_out_en, .xtal_load_trim, .synth_use_cnt, .synth_freq_mhz,
    .osc_slope_dn, .osc_slope_up);

// File: tb/test_rcpr_regs.sv
// Self-checking bench for the radio register group.
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    err_total++; $display("mismatch %0t: %h vs %h", $time, a, b); end end
module test_rcpr_regs;
    import rcpr_pkg::*;
    logic        clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [7:0]  a_cnt = 8'h5A, n_cnt = 8'hC3, a_out, n_out;
    logic        rx_mode = 0, lvl_ok = 0, rvalid, use_cnt, clk_en;
    logic [4:0]  lvl = 5'h00;
    logic [11:0] freq;
    logic [2:0]  pwr, s_dn, s_up;
    logic [5:0]  trim;
    logic [7:0]  ofs [6] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h26, 8'h25};
    logic [5:0]  sl [4] = '{6'h00, 6'h00, 6'h13, 6'h2D};
    int          err_total = 0, check_count = 0;
    always #50 clk_sys = ~clk_sys;
    rcpr_regs u_rcpr_regs (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(rvalid),
        .synth_a_cnt(a_cnt), .synth_n_cnt(n_cnt), .rx_mode(rx_mode),
        .rssi_level(lvl), .rssi_level_ok(lvl_ok), .synth_use_cnt(use_cnt),
        .synth_freq_mhz(freq), .synth_a_out(a_out), .synth_n_out(n_out),
        .tx_power_level(pwr), .ref_clock_out_en(clk_en),
        .xtal_load_trim(trim), .osc_slope_dn(s_dn), .osc_slope_up(s_up));
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic step(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Each access opens with a spare cycle so a strobe never drops and
    // rises in the same time step.
    task automatic wr(logic [7:0] a, logic [7:0] d);
        step(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        step(1);
        reg_wr = 0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        step(1);
        reg_addr = a;
        reg_rd = 1;
        step(1);
        reg_rd = 0;
        for (int i = 0; i < 4 && rvalid !== 1'b1; i++)
            step(1);
        if (rvalid !== 1'b1) begin
            err_total++;
            close_out();
        end else
            `CHK(reg_rdata, e)
    endtask
    initial begin
        step(10);
        sys_rst = 0;
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        `CHK({clk_en, freq}, 13'h1961)
        `CHK({a_out, n_out}, 16'h0000)
        for (int c = 1; c < 3; c++) begin
            wr(8'h21, 8'(c));
            step(2);
            `CHK(freq, 12'h0961 + 12'(c))
        end
        wr(8'h21, 8'h81);
        a_cnt = 8'h17;
        step(3);
        `CHK({use_cnt, a_out, n_out, freq}, 29'h117C_3000)
        rd(8'h21, 8'h81);
        for (int c = 0; c < 8; c++) begin
            wr(8'h23, 8'(c));
            `CHK(pwr, 3'(c))
        end
        rd(8'h23, 8'h07);
        wr(8'h24, 8'h6A);
        step(2);
        `CHK({clk_en, trim}, 7'h2A)
        rd(8'h24, 8'h6A);
        for (int c = 0; c < 4; c++) begin
            wr(8'h26, {2'(c), 6'h00});
            step(2);
            `CHK({s_dn, s_up}, sl[c])
        end
        rd(8'h26, 8'h00);
        lvl = 5'h13;
        lvl_ok = 1;
        rx_mode = 1;
        step(1);
        lvl = 5'h02;
        wr(8'h22, 8'hFF);
        rd(8'h22, 8'h33);
        rx_mode = 0;
        lvl_ok = 0;
        step(2);
        rx_mode = 1;
        rd(8'h22, 8'h02);
        close_out();
    end
endmodule
